// [hw/fec_codec_pkg.sv]
package fec_codec_pkg;
	// ----------------------------------------------------------------
	// Register map, byte addresses of aligned words.
	// ----------------------------------------------------------------
	localparam logic [7:0] addr_modem_config_one = 8'h00;
	localparam logic [7:0] addr_packet_control_zero = 8'h04;
	localparam logic [7:0] addr_packet_control_one = 8'h08;
	localparam logic [7:0] addr_link_quality = 8'h0c;
	localparam logic [7:0] addr_last_rssi = 8'h10;
	localparam int fld_error_coding_enable = 0;
	localparam int fld_status_bytes_append = 0;
	localparam logic [1:0] length_fixed = 2'h0;
	localparam logic [1:0] htrans_nonseq = 2'h2;
	localparam logic [2:0] hsize_word = 3'h2;
	// ----------------------------------------------------------------
	// Code and interleaver shape.
	// ----------------------------------------------------------------
	localparam int matrix_side = 4;
	localparam int constraint_len = 4;
	localparam logic [3:0] poly_a = 4'hb;
	localparam logic [3:0] poly_b = 4'hd;
	localparam int lqi_symbols = 64;
	localparam logic [7:0] pad_byte = 8'h0b;
	localparam logic [7:0] lqi_ok_flag = 8'h80;
endpackage

// [hw/packet_fec_interleave_codec.sv]
`timescale 1ns/1ps
// Contract
// - Code only when error_coding_enable is 1, else pass data uncoded.
// - Code the data field and CRC word only; earlier fields stay plain.
// - Rate one half convolutional code, constraint length four.
// - Exactly two coded bits leave for every data bit.
// - Interleave and de-interleave whenever coding is on, never otherwise.
// - Both interleaver buffers are four by four bit matrices.
// - Transmit writes rows, reads columns.
// - Receive writes columns, reads rows.
// - Append at least one trellis termination byte when coding.
// - Pad with one or two bytes so the coded length is an even number of blocks.
// - Receive drops padding and termination bytes before the FIFO.
// - Link quality accumulates error magnitude over 64 symbols after sync.
// - With appending on, link quality goes in the last status byte.
// - Latest link quality is readable in a status register.
// - With appending on, final signal strength goes in the first status byte.
module packet_fec_interleave_codec #(
	parameter int err_width = 8 // Width of one symbol error magnitude.
) (
	input wire logic hclk, // Bus and block clock.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire logic hsel, // Slave select.
	input wire logic [7:0] haddr, // Byte address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write when high.
	input wire logic [2:0] hsize, // Transfer size.
	input wire logic hready, // Bus ready in.
	input wire logic [31:0] hwdata, // Write data.
	output logic [31:0] hrdata, // Read data.
	output logic hreadyout, // Slave ready.
	output logic hresp, // Always OKAY.
	input wire logic tx_bit_valid, // Packet handler offers a bit.
	input wire logic tx_bit, // Bit from packet handler.
	input wire logic tx_coded_field, // Bit belongs to data field or CRC.
	input wire logic tx_packet_end, // Pulse: last coded bit has been offered.
	output logic tx_bit_ready, // Block takes the offered bit.
	output logic tx_air_valid, // Air bit strobe.
	output logic tx_air_bit, // Bit to modulator.
	input wire logic rx_sym_valid, // Demodulator symbol strobe.
	input wire logic rx_sym_bit, // Hard symbol from demodulator.
	input wire logic rx_coded_field, // Symbol is part of the coded region.
	input wire logic [15:0] rx_coded_bits, // Decoded payload bits before padding.
	input wire logic rx_sync_found, // Pulse at sync word detection.
	input wire logic [err_width-1:0] rx_sym_error, // Error magnitude of this symbol.
	input wire logic [7:0] rssi_value, // Current signal strength.
	input wire logic rx_payload_done, // Pulse after last payload byte.
	output logic rx_pair_valid, // Row-order pair strobe to decoder.
	output logic [1:0] rx_pair, // Coded bit pair to decoder.
	output logic rx_fifo_valid, // Byte to receive FIFO.
	output logic [7:0] rx_fifo_byte, // Payload or status byte.
	input wire logic rx_data_valid, // Decoded data bit strobe.
	input wire logic rx_data_bit // Decoded data bit.
);
	localparam int cells = fec_codec_pkg::matrix_side * fec_codec_pkg::matrix_side;
	// Data bits that fill one block, and the fill position of a block's last pair.
	localparam logic [3:0] data_per_block = 4'(cells / 2);
	localparam logic [3:0] last_pair = 4'(cells - 2);
	typedef enum logic [1:0] {tx_idle, tx_fill, tx_drain} tx_state_e;
	typedef enum logic [1:0] {st_off, st_rssi, st_lqi} stat_state_e;

	// ----------------------------------------------------------------
	// Register slave.
	// ----------------------------------------------------------------
	logic error_coding_enable;
	logic [1:0] length_mode;
	logic status_bytes_append;
	logic [7:0] link_quality_metric;
	logic [7:0] last_rssi;
	logic wr_pend;
	logic [7:0] wr_addr;
	wire take = hsel && hready && htrans == fec_codec_pkg::htrans_nonseq;
	wire word_ok = hsize == fec_codec_pkg::hsize_word;
	// A pending write lands in the data phase, when hwdata is valid.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= take && hwrite && word_ok;
			wr_addr <= haddr;
		end
	end
	wire wr_cfg1 = wr_pend && wr_addr == fec_codec_pkg::addr_modem_config_one;
	wire wr_ctl0 = wr_pend && wr_addr == fec_codec_pkg::addr_packet_control_zero;
	wire wr_ctl1 = wr_pend && wr_addr == fec_codec_pkg::addr_packet_control_one;
	logic [31:0] rd_mux;
	always_comb begin
		if (haddr == fec_codec_pkg::addr_modem_config_one) begin
			rd_mux = {31'h0, error_coding_enable};
		end else if (haddr == fec_codec_pkg::addr_packet_control_zero) begin
			rd_mux = {30'h0, length_mode};
		end else if (haddr == fec_codec_pkg::addr_packet_control_one) begin
			rd_mux = {31'h0, status_bytes_append};
		end else if (haddr == fec_codec_pkg::addr_link_quality) begin
			rd_mux = {24'h0, link_quality_metric};
		end else if (haddr == fec_codec_pkg::addr_last_rssi) begin
			rd_mux = {24'h0, last_rssi};
		end else begin
			rd_mux = 32'h0;
		end
	end
	// Zero wait states; unmapped reads return zero, unmapped writes vanish.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			error_coding_enable <= 1'b0;
			length_mode <= fec_codec_pkg::length_fixed;
			status_bytes_append <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (take && !hwrite) begin
				hrdata <= rd_mux;
			end
			if (wr_cfg1) begin
				error_coding_enable <= hwdata[fec_codec_pkg::fld_error_coding_enable];
			end
			if (wr_ctl0) begin
				length_mode <= hwdata[1:0];
			end
			if (wr_ctl1) begin
				status_bytes_append <= hwdata[fec_codec_pkg::fld_status_bytes_append];
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit encoder and interleaver.
	// ----------------------------------------------------------------
	// Coding only when software asked for it; variable length is the caller's duty.
	wire coding = error_coding_enable;
	tx_state_e tx_state;
	logic [fec_codec_pkg::constraint_len-2:0] enc_hist;
	logic [cells-1:0] tx_mat;
	logic [4:0] tx_fill_pos;
	logic [4:0] tx_out_pos;
	logic [3:0] pad_bits_left;
	logic tx_ending;
	logic tx_even_block;
	wire tx_pad_bit_w = pad_bits_left != 4'h0 ? 1'b0 : tx_bit;
	wire tx_coded_take = tx_bit_valid && tx_coded_field && coding && tx_state != tx_drain;
	// The first coded bit of a packet must already see cleared history and fill position.
	wire tx_fresh = tx_state == tx_idle && tx_coded_take;
	wire [fec_codec_pkg::constraint_len-2:0] hist_now = tx_fresh ? '0 : enc_hist;
	wire [4:0] fill_now = tx_fresh ? 5'h0 : tx_fill_pos;
	wire [3:0] enc_in = {tx_pad_bit_w, hist_now};
	wire code_a = ^(enc_in & fec_codec_pkg::poly_a);
	wire code_b = ^(enc_in & fec_codec_pkg::poly_b);
	wire tx_pad_step = tx_ending && tx_state == tx_fill;
	wire enc_step = tx_coded_take || tx_pad_step;
	// Column-major read of a row-major fill: cell index is row*4+col.
	wire [3:0] col_idx = {tx_out_pos[1:0], tx_out_pos[3:2]};
	assign tx_bit_ready = tx_state != tx_drain && !tx_ending;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_state <= tx_idle;
			enc_hist <= '0;
			tx_mat <= '0;
			tx_fill_pos <= 5'h0;
			tx_out_pos <= 5'h0;
			pad_bits_left <= 4'h0;
			tx_ending <= 1'b0;
			tx_even_block <= 1'b0;
			tx_air_valid <= 1'b0;
			tx_air_bit <= 1'b0;
		end else begin
			tx_air_valid <= 1'b0;
			if (tx_bit_valid && !tx_coded_field && tx_state == tx_idle) begin
				tx_air_valid <= 1'b1;
				tx_air_bit <= tx_bit;
			end else if (tx_bit_valid && !coding && tx_state == tx_idle) begin
				tx_air_valid <= 1'b1;
				tx_air_bit <= tx_bit;
			end
			if (tx_fresh) begin
				tx_even_block <= 1'b0;
			end
			if (enc_step) begin
				// Two coded bits per data bit, written along the current row.
				tx_mat[fill_now[3:0]] <= code_a;
				tx_mat[fill_now[3:0] + 4'h1] <= code_b;
				enc_hist <= enc_in[3:1];
				if (tx_pad_step) begin
					pad_bits_left <= pad_bits_left - 4'h1;
				end
				if (fill_now[3:0] == last_pair) begin
					tx_fill_pos <= 5'h0;
					tx_state <= tx_drain;
					tx_out_pos <= 5'h0;
				end else begin
					tx_fill_pos <= fill_now + 5'h2;
					tx_state <= tx_fill;
				end
			end
			if (tx_packet_end && coding) begin
				// One termination byte, plus one more when the data block count is even.
				tx_ending <= 1'b1;
				pad_bits_left <= data_per_block;
			end
			if (tx_state == tx_drain) begin
				tx_air_valid <= 1'b1;
				tx_air_bit <= tx_mat[col_idx];
				tx_out_pos <= tx_out_pos + 5'h1;
				if (tx_out_pos == 5'(cells - 1)) begin
					tx_even_block <= !tx_even_block;
					tx_state <= tx_fill;
					if (tx_ending && pad_bits_left == 4'h0 && tx_even_block) begin
						tx_ending <= 1'b0;
						tx_state <= tx_idle;
					end else if (tx_ending && pad_bits_left == 4'h0) begin
						pad_bits_left <= data_per_block;
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive de-interleaver, padding removal, link quality, status.
	// ----------------------------------------------------------------
	logic [cells-1:0] rx_mat;
	logic [4:0] rx_fill_pos;
	logic [3:0] rx_out_pos;
	logic rx_draining;
	logic [15:0] rx_bit_count;
	logic [7:0] rx_shift;
	logic [2:0] rx_bit_idx;
	logic [6:0] lqi_count;
	logic [err_width+6:0] lqi_acc;
	stat_state_e stat_state;
	// The running sum includes the current symbol, so the 64th symbol counts too.
	wire [err_width+6:0] lqi_sum = lqi_acc + (err_width + 7)'(rx_sym_error);
	// Column-first fill: symbol k lands at row k%4, column k/4.
	wire [3:0] rx_wr_idx = {rx_fill_pos[1:0], rx_fill_pos[3:2]};
	wire rx_keep = rx_bit_count < rx_coded_bits || !coding;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_mat <= '0;
			rx_fill_pos <= 5'h0;
			rx_out_pos <= 4'h0;
			rx_draining <= 1'b0;
			rx_pair_valid <= 1'b0;
			rx_pair <= 2'h0;
			rx_bit_count <= 16'h0;
			rx_shift <= 8'h0;
			rx_bit_idx <= 3'h0;
			rx_fifo_valid <= 1'b0;
			rx_fifo_byte <= 8'h0;
			lqi_count <= 7'h0;
			lqi_acc <= '0;
			link_quality_metric <= 8'h0;
			last_rssi <= 8'h0;
			stat_state <= st_off;
		end else begin
			rx_pair_valid <= 1'b0;
			rx_fifo_valid <= 1'b0;
			if (rx_sym_valid && rx_coded_field && coding && !rx_draining) begin
				rx_mat[rx_wr_idx] <= rx_sym_bit;
				if (rx_fill_pos == 5'(cells - 1)) begin
					rx_draining <= 1'b1;
					rx_out_pos <= 4'h0;
					rx_fill_pos <= 5'h0;
				end else begin
					rx_fill_pos <= rx_fill_pos + 5'h1;
				end
			end
			if (rx_draining) begin
				// Row order: consecutive cells of each row.
				rx_pair_valid <= 1'b1;
				rx_pair <= {rx_mat[rx_out_pos], rx_mat[rx_out_pos + 4'h1]};
				rx_out_pos <= rx_out_pos + 4'h2;
				if (rx_out_pos == last_pair) begin
					rx_draining <= 1'b0;
				end
			end
			if (rx_data_valid && rx_keep) begin
				rx_bit_count <= rx_bit_count + 16'h1;
				rx_shift <= {rx_shift[6:0], rx_data_bit};
				rx_bit_idx <= rx_bit_idx + 3'h1;
				if (rx_bit_idx == 3'h7) begin
					rx_fifo_valid <= 1'b1;
					rx_fifo_byte <= {rx_shift[6:0], rx_data_bit};
				end
			end
			if (rx_sync_found) begin
				lqi_count <= 7'h0;
				lqi_acc <= '0;
				rx_bit_count <= 16'h0;
				rx_bit_idx <= 3'h0;
				rx_fill_pos <= 5'h0;
				last_rssi <= rssi_value;
			end else if (rx_sym_valid && lqi_count != 7'(fec_codec_pkg::lqi_symbols)) begin
				lqi_acc <= lqi_sum;
				lqi_count <= lqi_count + 7'h1;
				last_rssi <= rssi_value;
				if (lqi_count == 7'(fec_codec_pkg::lqi_symbols - 1)) begin
					link_quality_metric <= 8'(lqi_sum >> (err_width - 1));
				end
			end else if (rx_sym_valid) begin
				last_rssi <= rssi_value;
			end
			case (stat_state)
				st_off: begin
					if (rx_payload_done && status_bytes_append) begin
						stat_state <= st_rssi;
					end
				end
				st_rssi: begin
					rx_fifo_valid <= 1'b1;
					rx_fifo_byte <= last_rssi;
					stat_state <= st_lqi;
				end
				default: begin
					rx_fifo_valid <= 1'b1;
					rx_fifo_byte <= link_quality_metric;
					stat_state <= st_off;
				end
			endcase
		end
	end
endmodule

// [verif/fec_chk_assertions.sv]
`timescale 1ns/1ps
// ---------------------------------
// Port checks on the codec block.
// ---------------------------------
module fec_chk (
	input wire logic hclk, // Clock.
	input wire logic hresetn, // Reset.
	input wire logic hsel, // Select.
	input wire logic [7:0] haddr, // Address.
	input wire logic [1:0] htrans, // Type.
	input wire logic hwrite, // Write.
	input wire logic [31:0] hwdata, // Data.
	input wire logic hreadyout, // Ready.
	input wire logic hresp, // Response.
	input wire logic tx_bit_valid, // Offer.
	input wire logic tx_coded_field, // Coded.
	input wire logic tx_bit_ready, // Taken.
	input wire logic tx_air_valid, // Air.
	input wire logic rx_sym_valid, // Symbol.
	input wire logic [7:0] rssi_value, // Strength.
	input wire logic rx_payload_done, // Done.
	input wire logic rx_pair_valid, // Pair.
	input wire logic rx_fifo_valid, // Byte.
	input wire logic [7:0] rx_fifo_byte // Value.
);
	logic wr_pend, coding, append;
	logic [7:0] wr_addr;
	logic [3:0] sym_cnt;
	logic [2:0] bit_cnt;
	// Handshake terms; coded bits count only when taken, but symbols count whenever valid with coding on.
	wire logic take = tx_bit_valid && tx_bit_ready;
	wire logic bit_take = take && tx_coded_field && coding;
	wire logic sym_take = rx_sym_valid && coding;
	// The enables are shadowed from bus writes, since no register is visible here.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{wr_pend, coding, append, sym_cnt, bit_cnt} <= 10'h000;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= hsel && hreadyout && htrans == fec_codec_pkg::htrans_nonseq && hwrite;
			wr_addr <= haddr;
			if (wr_pend && wr_addr == fec_codec_pkg::addr_modem_config_one) coding <= hwdata[0];
			if (wr_pend && wr_addr == fec_codec_pkg::addr_packet_control_one) append <= hwdata[0];
			if (sym_take) sym_cnt <= sym_cnt + 4'h1;
			if (bit_take) bit_cnt <= bit_cnt + 3'h1;
		end
	end
	// All properties share the block clock and its reset.
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_status; ##2 (rx_fifo_valid && rx_fifo_byte == $past(rssi_value)) ##1 rx_fifo_valid;
	endsequence
	property p_ready; hreadyout; endproperty
	a_ready: assert property (p_ready) else $error("slave inserted a wait state");
	property p_okay; !hresp; endproperty
	a_okay: assert property (p_okay) else $error("slave answered with an error");
	property p_take; bit_take && bit_cnt == 3'h7 |=> !tx_bit_ready; endproperty
	a_take: assert property (p_take) else $error("bit taken while matrix drains");
	property p_plain; take && !(coding && tx_coded_field) |=> tx_air_valid; endproperty
	a_plain: assert property (p_plain) else $error("plain bit not sent at once");
	property p_no_pair; !coding |-> !rx_pair_valid; endproperty
	a_no_pair: assert property (p_no_pair) else $error("pairs without coding");
	property p_pairs; sym_take && sym_cnt == 4'hf |-> ##[1:16] rx_pair_valid; endproperty
	a_pairs: assert property (p_pairs) else $error("full matrix not drained");
	property p_drain; bit_take && bit_cnt == 3'h7 |-> ##[1:40] tx_air_valid; endproperty
	a_drain: assert property (p_drain) else $error("coded byte not sent");
	property p_status; append && rx_payload_done |-> s_status; endproperty
	a_status: assert property (p_status) else $error("status bytes wrong");
endmodule

bind packet_fec_interleave_codec fec_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout),
	.hresp(hresp), .tx_bit_valid(tx_bit_valid), .tx_coded_field(tx_coded_field),
	.tx_bit_ready(tx_bit_ready), .tx_air_valid(tx_air_valid), .rx_sym_valid(rx_sym_valid),
	.rssi_value(rssi_value), .rx_payload_done(rx_payload_done), .rx_pair_valid(rx_pair_valid),
	.rx_fifo_valid(rx_fifo_valid), .rx_fifo_byte(rx_fifo_byte));

// [verif/far_end.sv]
`timescale 1ns/1ps
// ------------------------------------
// Packet handler and modem stand-in.
// ------------------------------------
module far_end (
	input wire logic hclk, // Clock.
	input wire logic tx_bit_ready, // Taken.
	output logic tx_bit_valid, // Offer.
	output logic tx_bit, // Bit.
	output logic tx_coded_field, // Coded.
	output logic tx_packet_end, // End.
	output logic rx_sym_valid, // Symbol.
	output logic rx_sym_bit, // Symbol bit.
	output logic rx_coded_field, // Coded.
	output logic [15:0] rx_coded_bits, // Kept bits.
	output logic rx_sync_found, // Sync.
	output logic [7:0] rx_sym_error, // Error.
	output logic [7:0] rssi_value, // Strength.
	output logic rx_payload_done, // Done.
	output logic rx_data_valid, // Decoded.
	output logic rx_data_bit // Decoded bit.
);
	// Quiet lines at start; two payload bytes are kept after decoding.
	initial begin
		{tx_bit_valid, tx_bit, tx_coded_field, tx_packet_end, rx_sym_valid} = 5'h00;
		{rx_sym_bit, rx_coded_field, rx_sync_found, rx_payload_done, rx_data_valid} = 5'h00;
		rx_data_bit = 1'b0;
		rx_coded_bits = 16'h0010;
		rx_sym_error = 8'h00;
		rssi_value = 8'h5a;
	end
	// Each bit is held until taken; the line is inverted after release so it never looks held.
	task automatic send(input int plain, input int nbytes);
		for (int i = 0; i < plain + 8 * nbytes; i++) begin
			tx_bit_valid <= 1'b1;
			tx_bit <= i[0] ^ i[2];
			tx_coded_field <= i >= plain;
			@(posedge hclk);
			while (tx_bit_ready !== 1'b1) @(posedge hclk);
		end
		{tx_bit_valid, tx_coded_field, tx_packet_end} <= 3'h1;
		tx_bit <= ~tx_bit;
		@(posedge hclk);
		tx_packet_end <= 1'b0;
	endtask
	// Sync, 64 coded symbols of one error size, 32 decoded bits, then the payload end.
	task automatic receive(input logic [7:0] err);
		rx_sync_found <= 1'b1;
		rx_sym_error <= err;
		@(posedge hclk);
		rx_sync_found <= 1'b0;
		// Symbols come far slower than the clock, so a block drains before the next fills.
		for (int i = 0; i < 64; i++) begin
			{rx_sym_valid, rx_coded_field, rx_sym_bit} <= {2'h3, i[0] ^ i[3]};
			@(posedge hclk);
			rx_sym_valid <= 1'b0;
			repeat (9) @(posedge hclk);
		end
		{rx_sym_valid, rx_coded_field, rx_sym_bit} <= {2'h0, ~rx_sym_bit};
		for (int i = 0; i < 32; i++) begin
			{rx_data_valid, rx_data_bit} <= {1'b1, i[0]};
			@(posedge hclk);
		end
		{rx_data_valid, rx_payload_done} <= 2'h1;
		@(posedge hclk);
		rx_payload_done <= 1'b0;
		repeat (4) @(posedge hclk);
	endtask
endmodule

// [verif/tb_top.sv]
`timescale 1ns/1ps
// ----------------------
// Codec block testbench.
// ----------------------
module tb_top;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0, hrdata;
	logic hreadyout, hresp, tx_bit_valid, tx_bit, tx_coded_field, tx_packet_end, tx_bit_ready;
	logic tx_air_valid, tx_air_bit, rx_sym_valid, rx_sym_bit, rx_coded_field, rx_sync_found;
	logic rx_payload_done, rx_pair_valid, rx_fifo_valid, rx_data_valid, rx_data_bit;
	logic [15:0] rx_coded_bits, last_bytes = 16'h0, pair_bits = 16'h0;
	logic [7:0] rx_sym_error, rssi_value, rx_fifo_byte;
	logic [1:0] rx_pair;
	logic [127:0] air_bits = 128'h0;
	int air_n = 0, pair_n = 0, fifo_n = 0, mismatches = 0, check_count = 0;
	always #20 hclk = ~hclk;
	packet_fec_interleave_codec u_packet_fec_interleave_codec (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .tx_bit_valid(tx_bit_valid), .tx_bit(tx_bit),
		.tx_coded_field(tx_coded_field), .tx_packet_end(tx_packet_end),
		.tx_bit_ready(tx_bit_ready), .tx_air_valid(tx_air_valid), .tx_air_bit(tx_air_bit),
		.rx_sym_valid(rx_sym_valid), .rx_sym_bit(rx_sym_bit), .rx_coded_field(rx_coded_field),
		.rx_coded_bits(rx_coded_bits), .rx_sync_found(rx_sync_found),
		.rx_sym_error(rx_sym_error), .rssi_value(rssi_value), .rx_payload_done(rx_payload_done),
		.rx_pair_valid(rx_pair_valid), .rx_pair(rx_pair), .rx_fifo_valid(rx_fifo_valid),
		.rx_fifo_byte(rx_fifo_byte), .rx_data_valid(rx_data_valid), .rx_data_bit(rx_data_bit));
	far_end u_far_end (.hclk(hclk), .tx_bit_ready(tx_bit_ready), .tx_bit_valid(tx_bit_valid),
		.tx_bit(tx_bit), .tx_coded_field(tx_coded_field), .tx_packet_end(tx_packet_end),
		.rx_sym_valid(rx_sym_valid), .rx_sym_bit(rx_sym_bit), .rx_coded_field(rx_coded_field),
		.rx_coded_bits(rx_coded_bits), .rx_sync_found(rx_sync_found),
		.rx_sym_error(rx_sym_error), .rssi_value(rssi_value), .rx_payload_done(rx_payload_done),
		.rx_data_valid(rx_data_valid), .rx_data_bit(rx_data_bit));
	// Tally what reaches the modulator, the decoder and the receive FIFO.
	always @(posedge hclk) begin
		if (tx_air_valid) air_bits <= {air_bits[126:0], tx_air_bit};
		if (rx_fifo_valid) last_bytes <= {last_bytes[7:0], rx_fifo_byte};
		if (rx_pair_valid) pair_bits <= {pair_bits[13:0], rx_pair};
		air_n <= air_n + tx_air_valid;
		pair_n <= pair_n + rx_pair_valid;
		fifo_n <= fifo_n + rx_fifo_valid;
	end
	task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		if (mismatches == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Expected air stream of one send: plain bits, then coded blocks read out by column.
	function automatic logic [71:0] ref_air(input logic coded);
		logic [3:0] win;
		logic [15:0] blk;
		logic [71:0] s;
		int n;
		win = 4'h0;
		blk = 16'h0;
		s = 72'h0;
		for (n = 0; n < (coded ? 8 : 24); n++) s = {s[70:0], n[0] ^ n[2]};
		for (int k = 0; coded && k < 4; k++) begin
			for (int j = 0; j < 8; j++) begin
				n = 8 + 8 * k + j;
				win = {k < 2 && (n[0] ^ n[2]), win[3:1]};
				blk[2 * j] = ^(win & fec_codec_pkg::poly_a);
				blk[2 * j + 1] = ^(win & fec_codec_pkg::poly_b);
			end
			for (int c = 0; c < 16; c++) s = {s[70:0], blk[4 * (c % 4) + c / 4]};
		end
		return s;
	endfunction
	// One single word transfer; read data is taken at the end of the data phase.
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		{hsel, htrans, haddr, hwrite} <= {1'b1, fec_codec_pkg::htrans_nonseq, a, wr};
		hsize <= fec_codec_pkg::hsize_word;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		{htrans, hwdata} <= {2'h0, wd};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	// Wait, with a bound, until the air output has been quiet for a while.
	task automatic settle();
		int quiet;
		quiet = 0;
		for (int k = 0; k < 400 && quiet < 40; k++) begin
			@(posedge hclk);
			quiet = tx_air_valid ? 0 : quiet + 1;
		end
	endtask
	task automatic t_regs();
		logic [31:0] rd;
		ahb(1'b1, fec_codec_pkg::addr_packet_control_zero, 32'h1, rd);
		ahb(1'b0, fec_codec_pkg::addr_packet_control_zero, 32'h0, rd);
		check("length_field", rd, 128'h1);
		ahb(1'b1, fec_codec_pkg::addr_packet_control_zero, 32'h0, rd);
		ahb(1'b1, fec_codec_pkg::addr_packet_control_one, 32'hffffffff, rd);
		ahb(1'b0, fec_codec_pkg::addr_packet_control_one, 32'h0, rd);
		check("append_field", rd, 128'h1);
		ahb(1'b1, 8'h40, 32'hffffffff, rd);
		ahb(1'b0, 8'h40, 32'h0, rd);
		check("unmapped", rd, 128'h0);
	endtask
	task automatic t_coded();
		int n0;
		logic [127:0] first;
		logic [31:0] rd;
		n0 = air_n;
		u_far_end.send(8, 2);
		settle();
		check("plain_air", air_n - n0, 24);
		check("plain_bits", air_bits[23:0], 24'(ref_air(1'b0)));
		ahb(1'b1, fec_codec_pkg::addr_modem_config_one, 32'h1, rd);
		ahb(1'b0, fec_codec_pkg::addr_modem_config_one, 32'h0, rd);
		check("coding_field", rd, 128'h1);
		n0 = air_n;
		u_far_end.send(8, 2);
		settle();
		first = air_bits;
		check("coded_air", air_n - n0, 72);
		check("coded_bits", air_bits[71:0], ref_air(1'b1));
		u_far_end.send(8, 2);
		settle();
		check("repeat_air", air_bits[71:0], first[71:0]);
	endtask
	task automatic t_rx();
		logic [31:0] lq0, lq, rd;
		logic [7:0] b0;
		int f0, p0;
		{f0, p0} = {fifo_n, pair_n};
		u_far_end.receive(8'h00);
		ahb(1'b0, fec_codec_pkg::addr_link_quality, 32'h0, lq0);
		check("fifo_count", fifo_n - f0, 4);
		check("rssi_byte", last_bytes[15:8], 128'h5a);
		check("pair_order", pair_bits, 128'h3c3c);
		ahb(1'b0, fec_codec_pkg::addr_last_rssi, 32'h0, rd);
		check("rssi_reg", rd, 128'h5a);
		b0 = last_bytes[7:0];
		u_far_end.receive(8'hff);
		ahb(1'b0, fec_codec_pkg::addr_link_quality, 32'h0, lq);
		check("lqi_reg_moves", lq != lq0, 128'h1);
		check("lqi_reg", lq, 128'h7f);
		check("lqi_byte_moves", last_bytes[7:0] != b0, 128'h1);
		ahb(1'b1, fec_codec_pkg::addr_packet_control_one, 32'h0, rd);
		f0 = fifo_n;
		u_far_end.receive(8'h00);
		check("no_status", fifo_n - f0, 2);
		check("data_bytes", last_bytes, 128'h5555);
		check("pairs", pair_n - p0, 96);
	endtask
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_coded();
		t_rx();
		conclude();
	end
	// Watchdog well beyond the few thousand cycles the run needs.
	initial begin
		#400000;
		mismatches++;
		conclude();
	end
endmodule
